// ==== logic/octal_dac_params.svh ====
// Constants for the octal converter serial load logic
`ifndef OCTAL_DAC_PARAMS_SVH
`define OCTAL_DAC_PARAMS_SVH

// Serial frame layout
`define FRAME_BITS        16
`define ADDR_BITS         4
`define ADDR_MSB          15
`define CODE_MSB          11
`define CHANNELS          8
`define CODE_BITS_MAX     10
`define CODE_BITS_DEFAULT 10

// Address codes
`define ADDR_CHAN_FIRST   4'h1
`define ADDR_CHAN_LAST    4'h8
`define ADDR_SLEEP        4'he
`define ADDR_ALL          4'hf

// Register byte offsets
`define REG_ADDR_BITS     12
`define OFS_CTRL          12'h000
`define OFS_STATUS        12'h004
`define OFS_FRAMES        12'h008
`define OFS_LAST_WORD     12'h00c
`define OFS_CHAN_BASE     12'h020

// Field positions
`define CTRL_ZERO_BIT     0
`define CTRL_INHIBIT_BIT  1
`define STATUS_SLEEP_BIT  0
`define STATUS_BUSY_BIT   1
`define STATUS_WOKE_BIT   2
`define STATUS_ADDR_LSB   8

// Reset values
`define RST_STROBE        1'b1
`define RST_FLAG          1'b0
`define RST_COUNT         16'h0000
`define RST_WORD          16'h0000
`define RST_RDATA         32'h0000_0000
`define RST_CODE          10'h000

`endif

// ==== logic/octal_dac_pkg.sv ====
// Types shared by the octal converter serial load logic
`include "octal_dac_params.svh"

package octal_dac_pkg;

    typedef enum logic [1:0] {
        LOAD_IDLE  = 2'b00,
        LOAD_LATCH = 2'b01,
        LOAD_APPLY = 2'b11
    } load_state_e;

    typedef struct packed {
        logic [`FRAME_BITS-1:0] shift;
    } link_state_s;

    typedef struct packed {
        logic [`CHANNELS-1:0]      mask;
        logic [`CODE_BITS_MAX-1:0] code;
        logic                      zero;
    } bank_write_s;

    typedef struct packed {
        logic                      strobe_sync1;
        logic                      strobe_sync2;
        logic                      strobe_seen;
        load_state_e               load;
        logic [`FRAME_BITS-1:0]    word;
        logic                      sleep;
        logic                      woke;
        logic                      inhibit;
        logic                      zero_req;
        logic [15:0]               frames;
        logic [15:0]               sleeps;
        logic [`FRAME_BITS-1:0]    last_word;
        logic                      dp_write;
        logic [`REG_ADDR_BITS-1:0] dp_addr;
        logic [31:0]               rdata;
    } ctrl_state_s;

endpackage

// ==== logic/dac_channel_bank.sv ====
// Eight channel code registers with load and zeroing
`timescale 1ns/1ps
`include "octal_dac_params.svh"

module dac_channel_bank #(
    parameter int CODE_W = `CODE_BITS_DEFAULT
) (
    // Clock and clear
    input  wire logic                               clk_in,
    input  wire logic                               zero_rst_in,
    // Write port
    input  octal_dac_pkg::bank_write_s              wr_in,
    // Held codes
    output logic [`CHANNELS-1:0][CODE_W-1:0]        code_out
);

    typedef struct packed {
        logic [`CHANNELS-1:0][CODE_W-1:0] code;
    } bank_state_s;

    bank_state_s st;
    bank_state_s next_st;

    generate
        if (CODE_W != 8 && CODE_W != 10) begin : g_bad_width
            $error("dac_channel_bank: CODE_W must be 8 or 10");
        end
    endgenerate

    // A frame load beats a software zero in the same cycle
    always_comb begin
        next_st = st;
        for (int i = 0; i < `CHANNELS; i++) begin
            if (wr_in.mask[i]) begin
                next_st.code[i] = wr_in.code[CODE_W-1:0];
            end else if (wr_in.zero) begin
                next_st.code[i] = '0;
            end
        end
    end

    always_ff @(posedge clk_in or posedge zero_rst_in) begin
        if (zero_rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign code_out = st.code;

endmodule

// ==== logic/octal_dac_load.sv ====
// Serial load front end of the eight-channel converter with AHB-Lite view
`timescale 1ns/1ps
`include "octal_dac_params.svh"

// Notes on behaviour
// - Strobe low: shift serial input into 16-bit register each rising clock.
// - Frame: 4-bit address, code MSB first, then filler to 16 bits.
// - Strobe rising after a frame copies it into addressed channel registers.
// - Strobe high gates off the shift clock; shift register holds.
// - Serial output is shift register end, sixteen edges behind the input.
// - Clear input low zeroes shift and channel registers, no clock needed.
// - Power-up reset starts every channel at zero scale.
// - Address 1110 sleeps: interface alive, outputs disabled.
// - Sleep keeps all channel registers, restored on wake.
// - Sleep frame ignores its code bits and changes no channel.
// - Any other address wakes, including the no-change addresses.
// - Codes 1-8 load channels A-H; 1111 loads all; rest change nothing.
module octal_dac_load #(
    parameter int CODE_W = `CODE_BITS_DEFAULT
) (
    // System clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          sys_rst_in,
    // Serial link
    input  wire logic                          shift_clk_in,
    input  wire logic                          serial_data_in,
    input  wire logic                          select_load_strobe_n_in,
    input  wire logic                          async_zero_n_in,
    output logic                               serial_data_out,
    // Converter side
    output logic [`CHANNELS-1:0][CODE_W-1:0]   channel_code_out,
    output logic                               outputs_enable_out,
    output logic                               sleep_out,
    // AHB-Lite slave
    input  wire logic                          hsel_in,
    input  wire logic [31:0]                   haddr_in,
    input  wire logic [1:0]                    htrans_in,
    input  wire logic                          hwrite_in,
    input  wire logic [2:0]                    hsize_in,
    input  wire logic                          hready_in,
    input  wire logic [31:0]                   hwdata_in,
    output logic [31:0]                        hrdata_out,
    output logic                               hreadyout_out,
    output logic                               hresp_out
);

    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [7:0] CHAN_ONE   = 8'h01;

    localparam octal_dac_pkg::ctrl_state_s CTRL_RESET = '{
        strobe_sync1 : `RST_STROBE,
        strobe_sync2 : `RST_STROBE,
        strobe_seen  : `RST_STROBE,
        load         : octal_dac_pkg::LOAD_IDLE,
        word         : `RST_WORD,
        sleep        : `RST_FLAG,
        woke         : `RST_FLAG,
        inhibit      : `RST_FLAG,
        zero_req     : `RST_FLAG,
        frames       : `RST_COUNT,
        sleeps       : `RST_COUNT,
        last_word    : `RST_WORD,
        dp_write     : `RST_FLAG,
        dp_addr      : '0,
        rdata        : `RST_RDATA
    };

    generate
        if (CODE_W != 8 && CODE_W != 10) begin : g_bad_width
            $error("octal_dac_load: CODE_W must be 8 or 10");
        end
    endgenerate

    // Either reset source resets everything asynchronously; the strobe synchroniser and edge memory flops reset high, the rest to zero
    logic zero_rst;
    assign zero_rst = sys_rst_in | ~async_zero_n_in;

    // ---------------- Link domain ----------------

    octal_dac_pkg::link_state_s link;
    octal_dac_pkg::link_state_s next_link;

    // Strobe acts as the shift enable at the link clock itself; a
    // synchroniser here would swallow the first bits of every frame.
    always_comb begin
        next_link = link;
        if (!select_load_strobe_n_in) begin
            next_link.shift = {link.shift[`FRAME_BITS-2:0],
                               serial_data_in};
        end
    end

    always_ff @(posedge shift_clk_in or posedge zero_rst) begin
        if (zero_rst) begin
            link <= '0;
        end else begin
            link <= next_link;
        end
    end

    // Last stage drives the chain output directly
    assign serial_data_out = link.shift[`FRAME_BITS-1];

    // ---------------- System domain ----------------

    octal_dac_pkg::ctrl_state_s st;
    octal_dac_pkg::ctrl_state_s next_st;
    octal_dac_pkg::bank_write_s wr;

    logic [`ADDR_BITS-1:0]     frame_addr;
    logic [`CODE_BITS_MAX-1:0] frame_code;
    logic                      strobe_rise;
    logic                      bus_take;
    logic                      word_access;
    logic                      chan_hit;
    logic [2:0]                chan_index;
    logic [31:0]               read_value;

    // Field split of the captured frame; filler bits are dropped
    assign frame_addr = st.word[`ADDR_MSB -: `ADDR_BITS];
    assign frame_code = `CODE_BITS_MAX'(st.word[`CODE_MSB -: CODE_W]);

    assign strobe_rise = st.strobe_sync2 & ~st.strobe_seen;
    assign bus_take    = hsel_in & htrans_in[1] & hready_in;
    assign word_access = (hsize_in == HSIZE_WORD);
    assign chan_hit    = (haddr_in[`REG_ADDR_BITS-1:5] ==
                          7'(`OFS_CHAN_BASE >> 5));
    assign chan_index  = haddr_in[4:2];

    always_comb begin
        next_st    = st;
        wr         = '0;
        read_value = '0;

        // Two-stage strobe synchroniser, then edge memory
        next_st.strobe_sync1 = select_load_strobe_n_in;
        next_st.strobe_sync2 = st.strobe_sync1;
        next_st.strobe_seen  = st.strobe_sync2;
        next_st.zero_req     = 1'b0;
        wr.zero              = st.zero_req;

        case (st.load)
            octal_dac_pkg::LOAD_IDLE: begin
                if (strobe_rise) begin
                    next_st.load = octal_dac_pkg::LOAD_LATCH;
                end
            end
            octal_dac_pkg::LOAD_LATCH: begin
                // Shift register is frozen while strobe is high, so the
                // word is stable here; host high-time bounds the window.
                next_st.word = link.shift;
                next_st.load = octal_dac_pkg::LOAD_APPLY;
            end
            octal_dac_pkg::LOAD_APPLY: begin
                next_st.load = octal_dac_pkg::LOAD_IDLE;
                if (!st.inhibit) begin
                    next_st.frames    = st.frames + 16'h0001;
                    next_st.last_word = st.word;
                    wr.code           = frame_code;
                    if (frame_addr == `ADDR_SLEEP) begin
                        // Code bits ignored, all channels retained
                        next_st.sleep  = 1'b1;
                        next_st.sleeps = st.sleeps + 16'h0001;
                        wr.mask        = '0;
                    end else begin
                        next_st.sleep = 1'b0;
                        if (st.sleep) begin
                            next_st.woke = 1'b1;
                        end
                        if (frame_addr == `ADDR_ALL) begin
                            wr.mask = '1;
                        end else if (frame_addr >= `ADDR_CHAN_FIRST &&
                                     frame_addr <= `ADDR_CHAN_LAST) begin
                            wr.mask = CHAN_ONE <<
                                (frame_addr - `ADDR_CHAN_FIRST);
                        end
                    end
                end
            end
            default: begin
                next_st.load = octal_dac_pkg::LOAD_IDLE;
            end
        endcase

        // Data phase of a write; narrow writes are dropped
        if (st.dp_write) begin
            case (st.dp_addr)
                `OFS_CTRL: begin
                    next_st.inhibit  = hwdata_in[`CTRL_INHIBIT_BIT];
                    next_st.zero_req = hwdata_in[`CTRL_ZERO_BIT];
                end
                `OFS_STATUS: begin
                    // Write one clears; a wake in this cycle still sets
                    if (hwdata_in[`STATUS_WOKE_BIT] &&
                        !(st.load == octal_dac_pkg::LOAD_APPLY &&
                          !st.inhibit && st.sleep &&
                          frame_addr != `ADDR_SLEEP)) begin
                        next_st.woke = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Address phase: capture what the data phase will need
        next_st.dp_write = bus_take & hwrite_in & word_access;
        next_st.dp_addr  = haddr_in[`REG_ADDR_BITS-1:0];

        case (haddr_in[`REG_ADDR_BITS-1:0])
            `OFS_CTRL: begin
                read_value[`CTRL_INHIBIT_BIT] = next_st.inhibit;
            end
            `OFS_STATUS: begin
                read_value[`STATUS_SLEEP_BIT] = st.sleep;
                read_value[`STATUS_BUSY_BIT]  =
                    (st.load != octal_dac_pkg::LOAD_IDLE);
                read_value[`STATUS_WOKE_BIT]  = st.woke;
                read_value[`STATUS_ADDR_LSB +: `ADDR_BITS] =
                    st.last_word[`ADDR_MSB -: `ADDR_BITS];
            end
            `OFS_FRAMES: begin
                read_value = {st.sleeps, st.frames};
            end
            `OFS_LAST_WORD: begin
                read_value = 32'(st.last_word);
            end
            default: begin
                if (chan_hit) begin
                    read_value = 32'(channel_code_out[chan_index]);
                end
            end
        endcase

        if (bus_take && !hwrite_in) begin
            next_st.rdata = read_value;
        end
    end

    always_ff @(posedge clk_in or posedge zero_rst) begin
        if (zero_rst) begin
            st <= CTRL_RESET;
        end else begin
            st <= next_st;
        end
    end

    dac_channel_bank #(
        .CODE_W (CODE_W)
    ) u_bank (
        .clk_in      (clk_in),
        .zero_rst_in (zero_rst),
        .wr_in       (wr),
        .code_out    (channel_code_out)
    );

    // Codes stay in the bank while asleep; only the enable drops
    assign outputs_enable_out = ~st.sleep;
    assign sleep_out          = st.sleep;

    // Zero wait states, never an error
    assign hrdata_out    = st.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

endmodule

// ==== dv/octal_dac_load_sva.sv ====
// Assertion checker for the octal converter serial load logic
`timescale 1ns/1ps
`include "octal_dac_params.svh"
module octal_dac_load_sva #(
    parameter int CODE_W = `CODE_BITS_DEFAULT
) (
    // Clocks and resets
    input wire logic                     clk_in,
    input wire logic                     sys_rst_in,
    input wire logic                     shift_clk_in,
    input wire logic                     async_zero_n_in,
    // Serial link
    input wire logic                     serial_data_in,
    input wire logic                     select_load_strobe_n_in,
    input wire logic                     serial_data_out,
    // Converter side
    input wire logic [`CHANNELS-1:0][CODE_W-1:0] channel_code_out,
    input wire logic                     outputs_enable_out,
    input wire logic                     sleep_out
);
    logic [4:0] low_edges;
    // Unbroken strobe-low shift edges, so the delay line is full
    always_ff @(posedge shift_clk_in or posedge sys_rst_in
                or negedge async_zero_n_in) begin
        if (sys_rst_in || !async_zero_n_in) begin
            low_edges <= 5'h00;
        end else if (select_load_strobe_n_in) begin
            low_edges <= 5'h00;
        end else if (low_edges != 5'h10) begin
            low_edges <= low_edges + 5'h01;
        end
    end

    enable_sleep_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in)
        outputs_enable_out == !sleep_out) else $error("enable vs sleep");
    shift_hold_a: assert property (
        @(posedge shift_clk_in) disable iff (sys_rst_in || !async_zero_n_in)
        select_load_strobe_n_in && $past(select_load_strobe_n_in)
        |-> $stable(serial_data_out)) else $error("shifted while idle");
    out_delay_a: assert property (
        @(posedge shift_clk_in) disable iff (sys_rst_in || !async_zero_n_in)
        low_edges == 5'h10 |-> serial_data_out == $past(serial_data_in, 16))
        else $error("serial out delay wrong");
    zero_clear_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in) !async_zero_n_in
        |-> channel_code_out == '0 && !sleep_out && !serial_data_out)
        else $error("clear did not zero");
    power_zero_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in) $fell(sys_rst_in)
        |-> channel_code_out == '0 && !sleep_out) else $error("reset state");
    load_timing_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in) $changed(channel_code_out)
        && async_zero_n_in && $past(async_zero_n_in)
        |-> select_load_strobe_n_in && $past(select_load_strobe_n_in, 3))
        else $error("code changed without load");
    sleep_enter_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in) $rose(sleep_out)
        |-> $stable(channel_code_out) && $past(select_load_strobe_n_in, 3))
        else $error("bad sleep entry");
    sleep_keep_a: assert property (
        @(posedge clk_in) disable iff (sys_rst_in) sleep_out && $past(sleep_out)
        |-> $stable(channel_code_out)) else $error("code moved in sleep");
endmodule

bind octal_dac_load octal_dac_load_sva #(.CODE_W(CODE_W)) chk_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .shift_clk_in(shift_clk_in),
    .async_zero_n_in(async_zero_n_in), .serial_data_in(serial_data_in),
    .select_load_strobe_n_in(select_load_strobe_n_in),
    .serial_data_out(serial_data_out), .channel_code_out(channel_code_out),
    .outputs_enable_out(outputs_enable_out), .sleep_out(sleep_out)
);

// ==== dv/serial_host_model.sv ====
// Host model driving the three-wire serial load link
`timescale 1ns/1ps
module serial_host_model (
    // Link to the device
    output logic shift_clk_out,
    output logic data_out,
    output logic strobe_n_out
);
    initial begin
        shift_clk_out = 1'b0;
        data_out = 1'b0;
        strobe_n_out = 1'b1;
    end
    // Last n bits of w, MSB first, under one strobe; clock idles low
    task automatic send(input logic [31:0] w, input int n);
        strobe_n_out = 1'b0;
        #100;
        for (int i = n - 1; i >= 0; i--) begin
            data_out = w[i];
            #24 shift_clk_out = 1'b1;
            #24 shift_clk_out = 1'b0;
        end
        #30 strobe_n_out = 1'b1;
        // Released line must not keep a believable level
        data_out = ~data_out;
        #100;
    endtask
    // Clock pulses with the strobe high
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            data_out = 1'($urandom);
            #24 shift_clk_out = 1'b1;
            #24 shift_clk_out = 1'b0;
        end
    endtask
endmodule

// ==== dv/tb_octal_dac_load.sv ====
// Self-checking bench for the octal converter serial load logic
`timescale 1ns/1ps
`include "octal_dac_params.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_octal_dac_load;
    typedef struct {logic [31:0] e; logic [31:0] m; string n;} note_s;
    logic        clk_in;
    logic        sys_rst_in = 1'b1;
    logic        zero_n = 1'b1;
    logic        sclk, sdi, stb_n, sdo, oe, slp, hready, hresp;
    logic        hsel = 1'b1;
    logic        hwrite = 1'b0;
    logic        rd_ph = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = '0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata, w;
    logic [`CHANNELS-1:0][9:0] codes;
    logic [9:0]  mc [8] = '{default: '0};
    logic        ms = 1'b0;
    logic        wk = 1'b0;
    logic [3:0]  la = '0;
    logic [15:0] lw = '0;
    logic [15:0] nf = '0;
    logic [15:0] nsl = '0;
    int          errors = 0;
    int          checks = 0;
    note_s       q [$];
    note_s       t;

    serial_host_model host_u (.shift_clk_out(sclk), .data_out(sdi),
        .strobe_n_out(stb_n));
    octal_dac_load #(.CODE_W(10)) dut_u (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .shift_clk_in(sclk),
        .serial_data_in(sdi), .select_load_strobe_n_in(stb_n),
        .async_zero_n_in(zero_n), .serial_data_out(sdo),
        .channel_code_out(codes), .outputs_enable_out(oe), .sleep_out(slp),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready),
        .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wait_rdy();
        int k;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (hready !== 1'b1 && k < 20);
        if (hready !== 1'b1) begin
            errors++;
            end_of_test();
        end
    endtask

    // One single word transfer; reads leave a note for the monitor
    task automatic bus(input logic [11:0] a, input logic wr,
                       input logic [31:0] d, input logic [31:0] m,
                       input string n);
        @(posedge clk_in);
        haddr <= {20'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        if (wr) hwdata <= d;
        else q.push_back('{d & m, m, n});
        rd_ph <= !wr;
        wait_rdy();
        rd_ph <= 1'b0;
    endtask

    always @(posedge clk_in) begin
        if (rd_ph && hready === 1'b1) begin
            t = q.pop_front();
            `CHK(t.n, t.e, hrdata & t.m)
        end
    end

    task automatic apply(input logic [15:0] f);
        logic [3:0] a;
        a = f[15:12];
        // Woke is sticky: set by any waking frame seen while asleep
        if (ms && a != `ADDR_SLEEP) wk = 1'b1;
        ms = (a == `ADDR_SLEEP);
        if (a == `ADDR_SLEEP) nsl++;
        nf++;
        la = a;
        lw = f;
        if (a == `ADDR_ALL) mc = '{default: f[11:2]};
        else if (a >= `ADDR_CHAN_FIRST && a <= `ADDR_CHAN_LAST) mc[a-1] = f[11:2];
    endtask

    task automatic frame(input logic [15:0] f);
        host_u.send({16'h0, f}, 16);
        apply(f);
    endtask

    task automatic chk_all();
        logic [31:0] e;
        for (int i = 0; i < 8; i++)
            bus(12'(`OFS_CHAN_BASE + 4 * i), 0, {22'h0, mc[i]}, '1, "chan");
        e = {20'h0, la, 5'h0, wk, 1'b0, ms};
        bus(`OFS_STATUS, 0, e, '1, "status");
        bus(`OFS_FRAMES, 0, {nsl, nf}, '1, "frames");
        bus(`OFS_LAST_WORD, 0, {16'h0, lw}, '1, "last word");
        `CHK("sleep pin", ms, slp)
        `CHK("enable pin", !ms, oe)
    endtask

    initial begin
        repeat (5) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        void'($urandom(26));
        chk_all();
        $display("test reset done");
        for (int a = 0; a < 16; a++) begin
            frame({4'(a), 12'($urandom)});
            chk_all();
        end
        frame(16'he3a5);
        frame(16'h0000);
        chk_all();
        bus(`OFS_STATUS, 1, 32'h4, '0, "");
        wk = 1'b0;
        repeat (30) begin
            frame(16'($urandom));
            chk_all();
        end
        $display("test address codes done");
        w = $urandom;
        host_u.send(w, 32);
        apply(w[15:0]);
        chk_all();
        w = $urandom;
        host_u.send(w, 20);
        apply(w[15:0]);
        chk_all();
        // Empty frame reloads the held word, exposing idle shifting
        host_u.stray(6);
        host_u.send(32'h0, 0);
        apply(w[15:0]);
        chk_all();
        $display("test long frames done");
        frame(16'he000);
        @(posedge clk_in) zero_n <= 1'b0;
        repeat (12) @(posedge clk_in);
        zero_n <= 1'b1;
        mc = '{default: '0};
        ms = 1'b0;
        // Clear wipes every piece of system state, counters included
        wk = 1'b0;
        la = '0;
        lw = '0;
        nf = '0;
        nsl = '0;
        chk_all();
        host_u.send(32'h0, 0);
        apply(16'h0000);
        chk_all();
        $display("test clear done");
        bus(12'h100, 1, 32'h5a5a_5a5a, '0, "");
        bus(12'h100, 0, 32'h0, '1, "unmapped");
        bus(`OFS_CTRL, 1, 32'h2, '0, "");
        bus(`OFS_CTRL, 0, 32'h2, '1, "ctrl");
        // Inhibited frame must leave codes, flags and counters alone
        host_u.send(32'h1fff, 16);
        chk_all();
        bus(`OFS_CTRL, 1, 32'h0, '0, "");
        host_u.send(32'h0, 0);
        apply(16'h1fff);
        chk_all();
        $display("test registers done");
        end_of_test();
    end
endmodule
